// ### hdl/ocfr_overcurrent_fault_response.sv
// Over-current fault policy: response modes, retry timing, warning and status.
// Assumes a PMBus engine delivering decoded command writes and reads on ref_clk.
`default_nettype none
module ocfr_overcurrent_fault_response #(
  parameter int unsigned DELAY_CYC [8] = '{
    ocfr_pkg::DELAY_MIN_US[0] * ocfr_pkg::CLK_MHZ, ocfr_pkg::DELAY_MIN_US[1] * ocfr_pkg::CLK_MHZ,
    ocfr_pkg::DELAY_MIN_US[2] * ocfr_pkg::CLK_MHZ, ocfr_pkg::DELAY_MIN_US[3] * ocfr_pkg::CLK_MHZ,
    ocfr_pkg::DELAY_MIN_US[4] * ocfr_pkg::CLK_MHZ, ocfr_pkg::DELAY_MIN_US[5] * ocfr_pkg::CLK_MHZ,
    ocfr_pkg::DELAY_MIN_US[6] * ocfr_pkg::CLK_MHZ, ocfr_pkg::DELAY_MIN_US[7] * ocfr_pkg::CLK_MHZ},
  parameter int unsigned HICCUP_CYC = ocfr_pkg::HICCUP_MS * 1000 * ocfr_pkg::CLK_MHZ
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Decoded PMBus command port
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic      [15:0] cmd_rdata,
  output logic             cmd_rvalid,
  input  wire logic        clear_faults,
  input  wire logic        store_user_all,
  // Analog and pin inputs
  input  wire logic        peak_over_limit,
  input  wire logic        vout_uv_pin,
  input  wire logic        enable_pin,
  // Same-clock inputs
  input  wire logic        operation_on,
  input  wire logic        other_fault_off,
  input  wire logic        iout_valid,
  input  wire logic [10:0] iout_mantissa,
  // Power stage control
  output logic             output_enable,
  output logic             current_limit_active,
  // Status and alert
  output logic             alert_out_n,
  output logic             status_word_iout,
  output logic             status_byte_iout,
  output logic      [7:0]  output_current_status_reg,
  output logic             invalid_data_flag,
  // Nonvolatile store
  output logic             nvm_store_stb,
  output logic      [7:0]  nvm_action,
  output logic      [15:0] nvm_threshold
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic retry_bad(input logic [7:0] act);
    logic [2:0] r;
    r = act[ocfr_pkg::RETRY_MSB:ocfr_pkg::RETRY_LSB];
    retry_bad = (r != ocfr_pkg::RETRY_LATCH) && (r != ocfr_pkg::RETRY_HICCUP);
  endfunction

  function automatic logic exp_bad(input logic [15:0] thr);
    exp_bad = thr[ocfr_pkg::EXP_MSB:ocfr_pkg::EXP_LSB] != ocfr_pkg::WARN_EXP;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0] peak_sync_q;
  logic [1:0] uv_sync_q;
  logic [1:0] en_sync_q;
  logic       peak_s;
  logic       uv_s;
  logic       run_ok;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      peak_sync_q <= 2'h0;
      uv_sync_q   <= 2'h0;
      en_sync_q   <= 2'h0;
    end else begin
      peak_sync_q <= {peak_sync_q[0], peak_over_limit};
      uv_sync_q   <= {uv_sync_q[0], vout_uv_pin};
      en_sync_q   <= {en_sync_q[0], enable_pin};
    end
  end

  assign peak_s = peak_sync_q[1];
  assign uv_s   = uv_sync_q[1];
  assign run_ok = en_sync_q[1] && operation_on && !other_fault_off;

  ////////////////////////////////////////////////////////////////////////////////
  // Command registers
  logic [7:0]  action_q;
  logic [15:0] thresh_q;
  logic        wr_action;
  logic        wr_thresh;
  logic        inval_q;

  assign wr_action = cmd_valid && cmd_write && (cmd_code == ocfr_pkg::CMD_FAULT_ACTION);
  assign wr_thresh = cmd_valid && cmd_write && (cmd_code == ocfr_pkg::CMD_WARN_THRESH);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      action_q <= ocfr_pkg::ACTION_RESET;
      thresh_q <= ocfr_pkg::THRESH_RESET;
    end else begin
      if (wr_action && !retry_bad(cmd_wdata[7:0])) begin
        action_q <= cmd_wdata[7:0];
      end
      if (wr_thresh && !exp_bad(cmd_wdata)) begin
        thresh_q <= cmd_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      inval_q <= 1'b0;
    end else if ((wr_action && retry_bad(cmd_wdata[7:0])) ||
                 (wr_thresh && exp_bad(cmd_wdata))) begin
      inval_q <= 1'b1;
    end else if (clear_faults) begin
      inval_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_rdata  <= 16'h0000;
      cmd_rvalid <= 1'b0;
    end else begin
      cmd_rvalid <= cmd_valid && !cmd_write;
      if (cmd_valid && !cmd_write) begin
        case (cmd_code)
          ocfr_pkg::CMD_FAULT_ACTION: cmd_rdata <= {8'h00, action_q};
          ocfr_pkg::CMD_WARN_THRESH:  cmd_rdata <= thresh_q;
          default:                    cmd_rdata <= 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nvm_store_stb <= 1'b0;
      nvm_action    <= 8'h00;
      nvm_threshold <= 16'h0000;
    end else begin
      nvm_store_stb <= store_user_all;
      if (store_user_all) begin
        nvm_action    <= action_q;
        nvm_threshold <= thresh_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Response state machine
  ocfr_pkg::ocfr_mode_type  mode;
  ocfr_pkg::ocfr_state_type state_q;
  ocfr_pkg::ocfr_state_type state_d;
  logic [2:0]               retry;
  logic [2:0]               dly_code;
  logic [ocfr_pkg::CNT_W-1:0] cnt_q;
  logic [ocfr_pkg::CNT_W-1:0] dly_last;
  logic [ocfr_pkg::CNT_W-1:0] hic_last;

  assign mode     = ocfr_pkg::ocfr_mode_type'(action_q[ocfr_pkg::MODE_MSB:ocfr_pkg::MODE_LSB]);
  assign retry    = action_q[ocfr_pkg::RETRY_MSB:ocfr_pkg::RETRY_LSB];
  assign dly_code = action_q[ocfr_pkg::DELAY_MSB:ocfr_pkg::DELAY_LSB];
  assign dly_last = ocfr_pkg::CNT_W'(DELAY_CYC[dly_code] - 1);
  assign hic_last = ocfr_pkg::CNT_W'(HICCUP_CYC - 1);

  always_comb begin
    state_d = state_q;
    if (!run_ok) begin
      state_d = ocfr_pkg::OCFR_STOP;
    end else begin
      case (state_q)
        ocfr_pkg::OCFR_RUN: begin
          if (peak_s) begin
            case (mode)
              ocfr_pkg::OCFR_IGNORE:  state_d = ocfr_pkg::OCFR_RUN;
              ocfr_pkg::OCFR_UV_ONLY: state_d = uv_s ? ocfr_pkg::OCFR_OFF : ocfr_pkg::OCFR_RUN;
              ocfr_pkg::OCFR_TIMED:   state_d = ocfr_pkg::OCFR_LIMIT;
              default:                state_d = ocfr_pkg::OCFR_OFF;
            endcase
          end
        end
        ocfr_pkg::OCFR_LIMIT: begin
          if (!peak_s) begin
            state_d = ocfr_pkg::OCFR_RUN;
          end else if (cnt_q >= dly_last) begin
            state_d = ocfr_pkg::OCFR_OFF;
          end
        end
        ocfr_pkg::OCFR_OFF: begin
          if (clear_faults) begin
            state_d = ocfr_pkg::OCFR_RUN;
          end else if (retry == ocfr_pkg::RETRY_HICCUP && cnt_q >= hic_last) begin
            state_d = ocfr_pkg::OCFR_RUN;
          end
        end
        ocfr_pkg::OCFR_STOP: state_d = ocfr_pkg::OCFR_RUN;
        default:             state_d = ocfr_pkg::OCFR_STOP;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ocfr_pkg::OCFR_STOP;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (state_d != state_q) begin
      cnt_q <= '0;
    end else if (cnt_q != '1) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign output_enable = (state_q == ocfr_pkg::OCFR_RUN) || (state_q == ocfr_pkg::OCFR_LIMIT);
  assign current_limit_active = output_enable && peak_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky status and alert
  logic fault_q;
  logic warn_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else if (peak_s) begin
      fault_q <= 1'b1;
    end else if (clear_faults) begin
      fault_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      warn_q <= 1'b0;
    end else if (iout_valid && (iout_mantissa >= thresh_q[ocfr_pkg::MANT_MSB:0])) begin
      warn_q <= 1'b1;
    end else if (clear_faults) begin
      warn_q <= 1'b0;
    end
  end

  always_comb begin
    output_current_status_reg = 8'h00;
    output_current_status_reg[ocfr_pkg::SIOUT_FAULT_BIT] = fault_q;
    output_current_status_reg[ocfr_pkg::SIOUT_WARN_BIT]  = warn_q;
  end

  assign status_word_iout  = fault_q || warn_q;
  assign status_byte_iout  = fault_q;
  assign alert_out_n       = !fault_q;
  assign invalid_data_flag = inval_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_bad_action_write;
    wr_action && retry_bad(cmd_wdata[7:0]);
  endsequence

  sequence s_bad_exp_write;
    wr_thresh && exp_bad(cmd_wdata);
  endsequence

  a_status_set: assert property (peak_s |=> status_word_iout && status_byte_iout
      && output_current_status_reg[ocfr_pkg::SIOUT_FAULT_BIT])
    else $error("status bits not set on peak fault");
  a_alert_low: assert property (peak_s |=> !alert_out_n)
    else $error("alert not asserted on peak fault");
  a_fault_sticky: assert property (fault_q && !clear_faults |=> fault_q)
    else $error("fault bit dropped without clear");
  a_nvm_capture: assert property (store_user_all |=> nvm_store_stb
      && nvm_action == $past(action_q) && nvm_threshold == $past(thresh_q))
    else $error("store did not capture settings");
  a_ignore_runs: assert property (mode == ocfr_pkg::OCFR_IGNORE && run_ok
      && state_q == ocfr_pkg::OCFR_RUN ##1 run_ok |-> state_q == ocfr_pkg::OCFR_RUN)
    else $error("ignore mode left run");
  a_shut_now: assert property (mode == ocfr_pkg::OCFR_SHUT && peak_s && run_ok
      && state_q == ocfr_pkg::OCFR_RUN |=> !output_enable) else $error("no shutdown");
  a_latch_hold: assert property (state_q == ocfr_pkg::OCFR_OFF && retry ==
      ocfr_pkg::RETRY_LATCH && !clear_faults && run_ok |=> state_q == ocfr_pkg::OCFR_OFF)
    else $error("latch-off restarted");
  a_retry_reject: assert property (s_bad_action_write |=> invalid_data_flag
      && $stable(action_q)) else $error("bad retry write accepted");
  a_exp_reject: assert property (s_bad_exp_write |=> invalid_data_flag
      && $stable(thresh_q)) else $error("bad exponent write accepted");
  a_limit_release: assert property (state_q == ocfr_pkg::OCFR_LIMIT && !peak_s
      && run_ok |=> state_q == ocfr_pkg::OCFR_RUN && cnt_q == '0)
    else $error("limit timer not released");
  a_warn_set: assert property (iout_valid
      && iout_mantissa >= thresh_q[ocfr_pkg::MANT_MSB:0]
      |=> output_current_status_reg[ocfr_pkg::SIOUT_WARN_BIT] && status_word_iout)
    else $error("warning missed");

endmodule
`default_nettype wire

// ### hdl/ocfr_pkg.sv
// Constants, field layout and types of the over-current fault response block.
// Assumes one controller clock of 25 MHz and a decoded PMBus command port.
`default_nettype none
package ocfr_pkg;
  localparam logic [7:0]  CMD_FAULT_ACTION = 8'h47;
  localparam logic [7:0]  CMD_WARN_THRESH  = 8'h4a;
  localparam logic [7:0]  ACTION_RESET     = 8'h80;
  localparam logic [15:0] THRESH_RESET     = 16'he250;
  localparam int          MODE_MSB         = 7;
  localparam int          MODE_LSB         = 6;
  localparam int          RETRY_MSB        = 5;
  localparam int          RETRY_LSB        = 3;
  localparam int          DELAY_MSB        = 2;
  localparam int          DELAY_LSB        = 0;
  localparam int          EXP_MSB          = 15;
  localparam int          EXP_LSB          = 11;
  localparam int          MANT_MSB         = 10;
  localparam logic [2:0]  RETRY_LATCH      = 3'h0;
  localparam logic [2:0]  RETRY_HICCUP     = 3'h7;
  localparam logic [4:0]  WARN_EXP         = 5'h1c;
  localparam int          SIOUT_FAULT_BIT  = 7;
  localparam int          SIOUT_WARN_BIT   = 5;
  localparam int          CLK_MHZ          = 25;
  localparam int          HICCUP_MS        = 1000;
  localparam int          DELAY_MIN_US [8] = '{160, 320, 640, 1280, 2560, 5120, 9600, 10080};
  localparam int          CNT_W            = 26;

  typedef enum logic [1:0] {
    OCFR_IGNORE  = 2'b00,
    OCFR_UV_ONLY = 2'b01,
    OCFR_TIMED   = 2'b10,
    OCFR_SHUT    = 2'b11
  } ocfr_mode_type;

  typedef enum logic [2:0] {
    OCFR_RUN   = 3'b000,
    OCFR_LIMIT = 3'b001,
    OCFR_OFF   = 3'b010,
    OCFR_STOP  = 3'b011
  } ocfr_state_type;
endpackage
`default_nettype wire

// ### bench/ocfr_host_model.sv
// Host model: issues decoded PMBus commands to the fault response block.
// Assumes the bench calls wr and rd; lines change only after ref_clk edges.
`default_nettype none
module ocfr_host_model (
  // Clock
  input  wire logic        ref_clk,
  // Command port
  output var  logic        cmd_valid,
  output var  logic        cmd_write,
  output var  logic [7:0]  cmd_code,
  output var  logic [15:0] cmd_wdata,
  input  wire logic [15:0] cmd_rdata,
  input  wire logic        cmd_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle write strobe; data is scrambled once released
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_code  <= c;
    cmd_wdata <= d;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~d;
  endtask

  // Read strobe, then take data at the edge that sees cmd_rvalid
  task automatic rd(input logic [7:0] c, output logic [15:0] d);
    int n;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b0;
    cmd_code  <= c;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    for (n = 0; n < 4; n++) begin
      @(posedge ref_clk);
      if (cmd_rvalid === 1'b1) break;
    end
    d = (cmd_rvalid === 1'b1) ? cmd_rdata : 16'hxxxx;
  endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench of the over-current fault response block.
// Assumes the package, the design and the host model are compiled first.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst, cmd_valid, cmd_write, cmd_rvalid, clear_faults;
  logic        store_user_all, peak_over_limit, vout_uv_pin, enable_pin;
  logic        operation_on, other_fault_off, iout_valid, output_enable;
  logic        current_limit_active, alert_out_n, status_word_iout;
  logic        status_byte_iout, invalid_data_flag, nvm_store_stb;
  logic [7:0]  cmd_code, output_current_status_reg, nvm_action;
  logic [10:0] iout_mantissa;
  logic [15:0] cmd_wdata, cmd_rdata, nvm_threshold, d;
  int          mismatches, checked, cycles, n;

  ocfr_host_model ocfr_host_model_i (.ref_clk, .cmd_valid, .cmd_write, .cmd_code,
    .cmd_wdata, .cmd_rdata, .cmd_rvalid);

  ocfr_overcurrent_fault_response #(.DELAY_CYC('{4, 5, 6, 7, 8, 9, 10, 11}),
    .HICCUP_CYC(20)) ocfr_overcurrent_fault_response_i (.ref_clk, .rst, .cmd_valid,
    .cmd_write, .cmd_code, .cmd_wdata, .cmd_rdata, .cmd_rvalid, .clear_faults,
    .store_user_all, .peak_over_limit, .vout_uv_pin, .enable_pin, .operation_on,
    .other_fault_off, .iout_valid, .iout_mantissa, .output_enable,
    .current_limit_active, .alert_out_n, .status_word_iout, .status_byte_iout,
    .output_current_status_reg, .invalid_data_flag, .nvm_store_stb, .nvm_action,
    .nvm_threshold);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic clr();
    @(posedge ref_clk) clear_faults <= 1'b1;
    @(posedge ref_clk) clear_faults <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic wait_oe(input logic v);
    for (n = 0; n < 200 && output_enable !== v; n++) @(negedge ref_clk);
    chk("output_enable", v, output_enable);
  endtask

  task automatic peak(input logic v);
    @(posedge ref_clk) peak_over_limit <= v;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    ocfr_host_model_i.rd(8'h47, d);
    chk("action reset", 16'h0080, d);
    ocfr_host_model_i.rd(8'h4a, d);
    chk("thresh reset", 16'he250, d);
    ocfr_host_model_i.rd(8'h30, d);
    chk("unmapped", 16'h0000, d);
    for (int r = 1; r < 7; r++) begin
      ocfr_host_model_i.wr(8'h47, {10'h003, r[2:0], 3'h0});
      @(negedge ref_clk);
      chk("invalid retry", 1, invalid_data_flag);
      clr();
    end
    ocfr_host_model_i.rd(8'h47, d);
    chk("action kept", 16'h0080, d);
    ocfr_host_model_i.wr(8'h4a, 16'he8a0);
    @(negedge ref_clk);
    chk("invalid exp", 1, invalid_data_flag);
    clr();
    ocfr_host_model_i.wr(8'h4a, 16'he7ff);
    ocfr_host_model_i.rd(8'h4a, d);
    chk("thresh max", 16'he7ff, d);
    chk("no invalid", 0, invalid_data_flag);
    $display("test regs done");
  endtask

  task automatic t_store();
    ocfr_host_model_i.wr(8'h47, 16'h00f8);
    ocfr_host_model_i.wr(8'h4a, 16'he0f0);
    @(posedge ref_clk) store_user_all <= 1'b1;
    @(posedge ref_clk) store_user_all <= 1'b0;
    @(negedge ref_clk);
    chk("store strobe", 1, nvm_store_stb);
    chk("store action", 16'h00f8, nvm_action);
    chk("store thresh", 16'he0f0, nvm_threshold);
    $display("test store done");
  endtask

  task automatic t_hiccup();
    peak(1'b1);
    wait_oe(1'b0);
    chk("shut fast", 1, n <= 5);
    peak(1'b0);
    wait_oe(1'b1);
    chk("hiccup time", 1, n >= 18 && n <= 24);
    clr();
    $display("test hiccup done");
  endtask

  task automatic t_latch();
    ocfr_host_model_i.wr(8'h47, 16'h00c0);
    peak(1'b1);
    wait_oe(1'b0);
    chk("alert", 0, alert_out_n);
    chk("word", 1, status_word_iout);
    chk("byte", 1, status_byte_iout);
    chk("iout status", 16'h0080, output_current_status_reg);
    peak(1'b0);
    repeat (30) @(negedge ref_clk);
    chk("latched", 0, output_enable);
    chk("sticky", 0, alert_out_n);
    clr();
    chk("alert clear", 1, alert_out_n);
    wait_oe(1'b1);
    $display("test latch done");
  endtask

  task automatic t_timed();
    ocfr_host_model_i.wr(8'h47, 16'h0087);
    repeat (2) begin
      peak(1'b1);
      repeat (8) @(posedge ref_clk);
      peak(1'b0);
      repeat (4) @(posedge ref_clk);
    end
    @(negedge ref_clk);
    chk("short limits", 1, output_enable);
    peak(1'b1);
    repeat (6) @(negedge ref_clk);
    chk("limiting", 1, current_limit_active);
    wait_oe(1'b0);
    chk("delay", 1, n >= 7 && n <= 11);
    peak(1'b0);
    clr();
    wait_oe(1'b1);
    $display("test timed done");
  endtask

  task automatic t_modes();
    ocfr_host_model_i.wr(8'h47, 16'h0000);
    peak(1'b1);
    repeat (20) @(negedge ref_clk);
    chk("ignore run", 1, output_enable);
    chk("ignore limit", 1, current_limit_active);
    chk("ignore alert", 0, alert_out_n);
    ocfr_host_model_i.wr(8'h47, 16'h0040);
    repeat (10) @(negedge ref_clk);
    chk("uv mode run", 1, output_enable);
    @(posedge ref_clk) vout_uv_pin <= 1'b1;
    wait_oe(1'b0);
    @(posedge ref_clk) vout_uv_pin <= 1'b0;
    peak(1'b0);
    clr();
    wait_oe(1'b1);
    $display("test modes done");
  endtask

  task automatic t_warn();
    ocfr_host_model_i.wr(8'h4a, 16'he0a0);
    for (int m = 16'h9f; m < 16'ha1; m++) begin
      @(posedge ref_clk);
      iout_valid    <= 1'b1;
      iout_mantissa <= m[10:0];
      @(posedge ref_clk) iout_valid <= 1'b0;
      @(negedge ref_clk);
      chk("warn bit", m == 16'ha0, output_current_status_reg[5]);
    end
    chk("warn word", 1, status_word_iout);
    $display("test warn done");
  endtask

  task automatic t_enable();
    ocfr_host_model_i.wr(8'h47, 16'h00f8);
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk) {enable_pin, operation_on, other_fault_off} <= 3'h6 ^ (3'h4 >> k);
      repeat (30) @(negedge ref_clk);
      chk("held off", 0, output_enable);
      @(posedge ref_clk) {enable_pin, operation_on, other_fault_off} <= 3'h6;
      wait_oe(1'b1);
    end
    @(posedge ref_clk) rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    chk("alert after reset", 1, alert_out_n);
    ocfr_host_model_i.rd(8'h47, d);
    chk("action after reset", 16'h0080, d);
    $display("test enable done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock, reset, timeout and sequence
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    rst = 1'b1;
    {clear_faults, store_user_all, peak_over_limit, vout_uv_pin} = 4'h0;
    {enable_pin, operation_on, other_fault_off, iout_valid} = 4'hc;
    iout_mantissa = 11'h000;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    wait_oe(1'b1);
    t_regs();
    t_store();
    t_hiccup();
    t_latch();
    t_timed();
    t_modes();
    t_warn();
    t_enable();
    end_of_test();
  end
endmodule
`default_nettype wire
